// ==== edd_frame_dma.sv ====
// Descriptor driven frame DMA between memory and the MAC, AHB-Lite slave
`timescale 1ns/1ps
`include "edd_defs.svh"
// Operation
// - Frame data moves in bursts of at most 32 bytes (eight words).
// - Every frame's status is written back into its own descriptor.
// - Configurable zero padding words precede received data in the buffer.
// - Module stop bit halts the engine before any new descriptor.
// - Carrier flag is 0 if carrier seen in preamble, else 1.
// - Receive write monitor holds last address written with receive data.
// - Receive write monitor follows completed beats, may lag issued address.
// - Receive fetch monitor holds start of last fetched receive descriptor.
// - Transmit read monitor holds last address read with transmit data.
// - Transmit fetch monitor holds start of last fetched transmit descriptor.
// - Mode bit 0: transmit interrupt on each finished frame.
// - Mode bit 1: interrupt after write-back of a descriptor requesting it.
// - MAC CRC errors reported only while CRC receive mode bit is 0.
module edd_frame_dma (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic             irqOut,
   output logic             memReq,
   output logic             memWrite,
   output logic [31:0]      memAddr,
   output logic [3:0]       memLen,
   output logic [31:0]      memWdata,
   input  wire logic        memAck,
   input  wire logic [31:0] memRdata,
   output logic [31:0]      txData,
   output logic             txValid,
   output logic             txLast,
   input  wire logic        macTxReady,
   input  wire logic        macTxPreamble,
   input  wire logic        macCarrier,
   input  wire logic        macTxDone,
   input  wire logic [31:0] rxData,
   input  wire logic        rxValid,
   input  wire logic        rxLast,
   input  wire logic        rxCrcErr,
   output logic             rxReady
);
   import edd_pkg::*;

   edd_regs_t   q, n;
   logic        beat, last;
   logic [31:0] beatAddr;
   logic [3:0]  set, clr;

   // Start a burst on the memory master port
   function automatic edd_regs_t issue(edd_regs_t r, logic w,
                                       logic [31:0] a, logic [3:0] l);
      r.memReq = 1'b1;
      r.memWrite = w;
      r.memAddr = a;
      r.memLen = l;
      r.cnt = 4'h0;
      r.memWdata = r.blk[0];
      return r;
   endfunction : issue

   // Burst size capped at one block
   function automatic logic [3:0] burstOf(logic [13:0] w);
      return (w >= 14'h8) ? `EDD_BURST : w[3:0];
   endfunction : burstOf

   // Next descriptor address, wrapping to the ring base
   function automatic logic [31:0] nextPtr(logic [31:0] d, logic [31:0] p,
                                           logic [31:0] b);
      return d[`EDD_D_WRAP] ? b : p + `EDD_DSC_STEP;
   endfunction : nextPtr

   always_comb begin
      n = q;
      set = 4'h0;
      clr = 4'h0;
      beat = q.memReq & memAck;
      last = beat & (q.cnt == q.memLen - 4'h1);
      beatAddr = q.memAddr + {26'h0, q.cnt, 2'b00};
      // Bus address phase, read data captured here
      n.aWr = hsel & htrans[1] & hready & hwrite;
      if (hsel & htrans[1] & hready & ~hwrite) begin
         n.aAddr = haddr[7:0];
         case (haddr[7:0])
            `EDD_A_CTRL: n.hrdata = {26'h0, q.pad, q.crcMode, q.rxRun,
                                     q.txRun, q.stop};
            `EDD_A_TIM:  n.hrdata = {31'h0, q.tim};
            `EDD_A_STS:  n.hrdata = {28'h0, q.sts};
            `EDD_A_MSK:  n.hrdata = {28'h0, q.msk};
            `EDD_A_TXB:  n.hrdata = q.txBase;
            `EDD_A_RXB:  n.hrdata = q.rxBase;
            `EDD_A_RBW:  n.hrdata = q.rbw;
            `EDD_A_RDF:  n.hrdata = q.rdf;
            `EDD_A_TBR:  n.hrdata = q.tbr;
            `EDD_A_TDF:  n.hrdata = q.tdf;
            default:     n.hrdata = 32'h0;
         endcase
      end else if (hsel & htrans[1] & hready) begin
         n.aAddr = haddr[7:0];
      end
      // Bus data phase, monitors ignore writes
      if (q.aWr) begin
         case (q.aAddr)
            `EDD_A_CTRL: begin
               n.stop = hwdata[`EDD_C_STOP];
               n.txRun = q.txRun | hwdata[`EDD_C_TXRUN];
               n.rxRun = hwdata[`EDD_C_RXRUN];
               n.crcMode = hwdata[`EDD_C_CRCM];
               n.pad = hwdata[`EDD_C_PADHI:`EDD_C_PADLO];
            end
            `EDD_A_TIM: n.tim = hwdata[0];
            `EDD_A_STS: clr = hwdata[3:0];
            `EDD_A_MSK: n.msk = hwdata[3:0];
            `EDD_A_TXB: begin
               n.txBase = hwdata;
               n.txPtr = hwdata;
            end
            `EDD_A_RXB: begin
               n.rxBase = hwdata;
               n.rxPtr = hwdata;
            end
            default: ;
         endcase
      end
      // Memory beats and address monitors
      if (beat) begin
         n.cnt = q.cnt + 4'h1;
         if (q.memWrite) n.memWdata = q.blk[3'(q.cnt + 4'h1)];
         else n.blk[q.cnt[2:0]] = memRdata;
         if (last) n.memReq = 1'b0;
         if (q.st == ST_TXRD) n.tbr = beatAddr;
         if (q.st == ST_RXDATA) n.rbw = beatAddr;
      end
      // Main sequencer
      case (q.st)
         ST_IDLE: begin
            if (!q.stop && q.rxRun && rxValid) begin
               n = issue(n, 1'b0, q.rxPtr, `EDD_DSC_LEN);
               n.st = ST_RXDSC;
            end else if (!q.stop && q.txRun) begin
               n = issue(n, 1'b0, q.txPtr, `EDD_DSC_LEN);
               n.st = ST_TXDSC;
            end
         end
         ST_TXDSC: if (last) begin
            n.tdf = q.txPtr;
            if (!q.blk[0][`EDD_D_OWN]) begin
               n.txRun = 1'b0;
               n.st = ST_IDLE;
            end else begin
               n.dsc = q.blk[0];
               n.bufAddr = memRdata;
               n.remW = 14'((17'(q.blk[0][15:0]) + 17'h3) >> 2);
               n = issue(n, 1'b0, memRdata, burstOf(n.remW));
               n.st = ST_TXRD;
            end
         end
         ST_TXRD: if (last) begin
            n.idx = 4'h0;
            n.st = ST_TXPUSH;
         end
         ST_TXPUSH: begin
            if (!q.txValid) begin
               n.txData = q.blk[q.idx[2:0]];
               n.txValid = 1'b1;
               n.txLast = (q.remW == 14'h1);
            end else if (macTxReady) begin
               n.txValid = 1'b0;
               n.txLast = 1'b0;
               n.idx = q.idx + 4'h1;
               n.remW = q.remW - 14'h1;
               if (n.idx == q.memLen) begin
                  n.bufAddr = q.bufAddr + {26'h0, q.memLen, 2'b00};
                  if (n.remW == 14'h0) begin
                     n.wr = 1'b0;
                     n.st = ST_TXWB;
                  end else begin
                     n = issue(n, 1'b0, n.bufAddr, burstOf(n.remW));
                     n.st = ST_TXRD;
                  end
               end
            end
         end
         ST_TXWB: begin
            if (!q.wr && q.txFin) begin
               n.blk[0] = q.dsc;
               n.blk[0][`EDD_D_OWN] = 1'b0;
               n.blk[0][`EDD_D_CND] = q.carMiss;
               n = issue(n, 1'b1, q.txPtr, 4'h1);
               n.wr = 1'b1;
               n.txFin = 1'b0;
            end else if (last) begin
               n.wr = 1'b0;
               n.txPtr = nextPtr(q.dsc, q.txPtr, q.txBase);
               set[`EDD_S_TX] = q.tim & q.dsc[`EDD_D_WRITEBACK_IRQ_REQUEST_BIT];
               n.st = ST_IDLE;
            end
         end
         ST_RXDSC: if (last) begin
            n.rdf = q.rxPtr;
            if (!q.blk[0][`EDD_D_OWN]) begin
               n.st = ST_IDLE;
            end else begin
               n.dsc = q.blk[0];
               n.bufAddr = memRdata;
               n.idx = 4'h0;
               n.padLeft = q.pad;
               n.lastIn = 1'b0;
               n.crcIn = 1'b0;
               n.rxWords = 14'h0;
               n.wr = 1'b0;
               n.st = ST_RXDATA;
            end
         end
         ST_RXDATA: begin
            if (q.wr) begin
               if (last) begin
                  n.wr = 1'b0;
                  n.idx = 4'h0;
                  n.bufAddr = q.bufAddr + {26'h0, q.memLen, 2'b00};
                  if (q.lastIn) begin
                     n.blk[0] = q.dsc;
                     n.blk[0][`EDD_D_OWN] = 1'b0;
                     n.blk[0][`EDD_D_CRC] = q.crcIn;
                     n.blk[0][15:0] = {q.rxWords, 2'b00};
                     n = issue(n, 1'b1, q.rxPtr, 4'h1);
                     n.st = ST_RXWB;
                  end
               end
            end else if (q.padLeft != 2'h0) begin
               n.blk[q.idx[2:0]] = 32'h0;
               n.idx = q.idx + 4'h1;
               n.padLeft = q.padLeft - 2'h1;
            end else if (q.rxReady && rxValid) begin
               n.blk[q.idx[2:0]] = rxData;
               n.idx = q.idx + 4'h1;
               n.rxWords = q.rxWords + 14'h1;
               if (rxLast) begin
                  n.lastIn = 1'b1;
                  n.crcIn = rxCrcErr & ~q.crcMode;
               end
            end else if (q.idx == `EDD_BURST || q.lastIn) begin
               n = issue(n, 1'b1, q.bufAddr, q.idx);
               n.wr = 1'b1;
            end
         end
         ST_RXWB: if (last) begin
            n.rxPtr = nextPtr(q.dsc, q.rxPtr, q.rxBase);
            set[`EDD_S_RX] = 1'b1;
            set[`EDD_S_CRC] = q.crcIn;
            n.st = ST_IDLE;
         end
         default: n.st = ST_IDLE;
      endcase
      n.rxReady = (n.st == ST_RXDATA) & ~n.wr & ~n.lastIn &
                  (n.padLeft == 2'h0) & (n.idx < `EDD_BURST);
      // Carrier watch during the preamble of each frame
      if (macTxPreamble & macCarrier) n.carSeen = 1'b1;
      if (macTxDone) begin
         n.carMiss = ~(q.carSeen | (macTxPreamble & macCarrier));
         n.carSeen = 1'b0;
         n.txFin = 1'b1;
         set[`EDD_S_CND] = n.carMiss;
         if (!q.tim) set[`EDD_S_TX] = 1'b1;
      end
      // Sticky status, set wins over clear
      n.sts = (q.sts & ~clr) | set;
      n.irq = |(n.sts & n.msk);
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         q <= '0;
         q.stop <= `EDD_RST_STOP;
         q.rdy <= `EDD_RST_RDY;
      end else begin
         q <= n;
      end
   end

   // Outputs straight from the state register
   assign hreadyout = q.rdy;
   assign hresp = q.resp;
   assign hrdata = q.hrdata;
   assign irqOut = q.irq;
   assign memReq = q.memReq;
   assign memWrite = q.memWrite;
   assign memAddr = q.memAddr;
   assign memLen = q.memLen;
   assign memWdata = q.memWdata;
   assign txData = q.txData;
   assign txValid = q.txValid;
   assign txLast = q.txLast;
   assign rxReady = q.rxReady;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   chk_burst_size: assert property ($rose(q.memReq) |->
      q.memLen <= `EDD_BURST && q.memLen != 4'h0)
      else $error("burst longer than a block");
   chk_wb_owner: assert property (q.memReq && (q.st == ST_RXWB ||
      q.st == ST_TXWB) |-> q.memWrite && !q.memWdata[`EDD_D_OWN])
      else $error("write-back keeps ownership");
   chk_pad_first: assert property ($rose(q.st == ST_RXDATA) &&
      q.padLeft != 2'h0 |-> !q.rxReady ##1 q.blk[0] == 32'h0)
      else $error("receive data before padding");
   chk_stop_hold: assert property (q.stop && q.st == ST_IDLE |=>
      q.st == ST_IDLE) else $error("engine left idle while stopped");
   chk_carrier_flag: assert property (macTxDone && !q.carSeen &&
      !macCarrier |=> q.sts[`EDD_S_CND] && q.carMiss)
      else $error("missing carrier not flagged");
   chk_rbw_track: assert property (beat && q.st == ST_RXDATA |=>
      q.rbw == $past(beatAddr)) else $error("receive monitor stale");
   chk_rdf_track: assert property (last && q.st == ST_RXDSC
      |=> q.rdf == $past(q.rxPtr))
      else $error("receive fetch monitor stale");
   chk_tbr_track: assert property (beat && q.st == ST_TXRD |=>
      q.tbr == $past(beatAddr)) else $error("transmit monitor stale");
   chk_tdf_track: assert property (last && q.st == ST_TXDSC
      |=> q.tdf == $past(q.txPtr))
      else $error("transmit fetch monitor stale");
   chk_tx_frame: assert property (!q.tim && macTxDone |=>
      q.sts[`EDD_S_TX]) else $error("frame interrupt lost");
   chk_tx_wb: assert property (q.tim && last && q.st == ST_TXWB &&
      !q.dsc[`EDD_D_WRITEBACK_IRQ_REQUEST_BIT] && !q.sts[`EDD_S_TX] |=> !q.sts[`EDD_S_TX])
      else $error("write-back interrupt without request");
   chk_crc_mode: assert property (q.crcMode && q.rxReady && rxValid
      |=> !q.crcIn) else $error("CRC error reported in masked mode");
   cov_tx_frame: cover property (q.st == ST_TXWB && last);
   cov_rx_frame: cover property (q.st == ST_RXWB && last);
   cov_irq: cover property ($rose(q.irq));
endmodule : edd_frame_dma

// ==== edd_defs.svh ====
// Register offsets, field positions and reset values of the frame DMA
`ifndef EDD_DEFS_SVH
`define EDD_DEFS_SVH
`define EDD_A_CTRL   8'h00
`define EDD_A_TIM    8'h04
`define EDD_A_STS    8'h08
`define EDD_A_MSK    8'h0c
`define EDD_A_TXB    8'h10
`define EDD_A_RXB    8'h14
`define EDD_A_RBW    8'h18
`define EDD_A_RDF    8'h1c
`define EDD_A_TBR    8'h20
`define EDD_A_TDF    8'h24
`define EDD_C_STOP   0
`define EDD_C_TXRUN  1
`define EDD_C_RXRUN  2
`define EDD_C_CRCM   3
`define EDD_C_PADHI  5
`define EDD_C_PADLO  4
`define EDD_S_TX     0
`define EDD_S_RX     1
`define EDD_S_CRC    2
`define EDD_S_CND    3
`define EDD_D_OWN    31
`define EDD_D_WRAP   30
`define EDD_D_WRITEBACK_IRQ_REQUEST_BIT   29
`define EDD_D_CRC    27
`define EDD_D_CND    26
`define EDD_BURST    4'h8
`define EDD_DSC_LEN  4'h2
`define EDD_DSC_STEP 32'h8
`define EDD_RST_STOP 1'b1
`define EDD_RST_RDY  1'b1
`endif

// ==== edd_pkg.sv ====
// Types of the frame DMA engine
package edd_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0, ST_TXDSC = 4'h1, ST_TXRD = 4'h3, ST_TXPUSH = 4'h2,
      ST_TXWB = 4'h6, ST_RXDSC = 4'h7, ST_RXDATA = 4'h5, ST_RXWB = 4'h4
   } edd_state_t;
   typedef struct packed {
      edd_state_t        st;
      logic              stop, txRun, rxRun, crcMode, tim;
      logic [1:0]        pad, padLeft;
      logic [3:0]        sts, msk, cnt, idx, memLen;
      logic [31:0]       txBase, rxBase, txPtr, rxPtr;
      logic [31:0]       rbw, rdf, tbr, tdf, dsc, bufAddr;
      logic [13:0]       remW, rxWords;
      logic [7:0][31:0]  blk;
      logic              wr, lastIn, crcIn, carSeen, carMiss, txFin;
      logic              aWr, rdy, resp, irq;
      logic [7:0]        aAddr;
      logic [31:0]       hrdata, memAddr, memWdata, txData;
      logic              memReq, memWrite, txValid, txLast, rxReady;
   } edd_regs_t;
endpackage : edd_pkg

// ==== edd_far_model.sv ====
// Memory and MAC stand-in on the far side of the frame DMA
`timescale 1ns/1ps
module edd_far_model (
   input  wire logic        core_clk,
   input  wire logic        memReq,
   input  wire logic        memWrite,
   input  wire logic [31:0] memAddr,
   input  wire logic [3:0]  memLen,
   input  wire logic [31:0] memWdata,
   output logic             memAck,
   output logic [31:0]      memRdata,
   input  wire logic        txValid,
   input  wire logic        txLast,
   output logic             macTxReady,
   output logic             macTxPreamble,
   output logic             macCarrier,
   output logic             macTxDone,
   input  wire logic        carrierOn
);
   logic [31:0] mem [0:511];
   logic [31:0] noise;
   logic [8:0]  idx;
   logic [3:0]  beat = 4'h0;
   logic [2:0]  pre = 3'h0;
   logic        inFrame = 1'b0;
   initial begin
      memAck = 1'b0;
      macTxReady = 1'b0;
      macTxDone = 1'b0;
   end
   // Beat address steps one word per acknowledged beat
   assign idx = memAddr[10:2] + 9'(beat);
   // Read data only valid with an ack, noise otherwise
   assign memRdata = memAck ? mem[idx] : noise;
   assign macTxPreamble = pre != 3'h0;
   assign macCarrier = carrierOn & macTxPreamble;
   // Beats with random gaps, never past the burst length
   always @(posedge core_clk) begin
      noise <= $urandom;
      // Back-to-back bursts keep memReq high, so restart on the last beat
      if (memReq && memAck) begin
         beat <= (5'(beat) + 5'h1 == 5'(memLen)) ? 4'h0 : beat + 4'h1;
         if (memWrite) mem[idx] <= memWdata;
      end
      if (!memReq) beat <= 4'h0;
      memAck <= memReq && (5'(beat) + 5'(memAck) < 5'(memLen))
                && $urandom_range(3) != 0;
      // Preamble first, then words with random stalls, then done pulse
      macTxReady <= pre == 3'h0 && inFrame && $urandom_range(1) == 1;
      macTxDone <= txValid && macTxReady && txLast;
      if (pre != 3'h0) pre <= pre - 3'h1;
      if (txValid && !inFrame) begin
         inFrame <= 1'b1;
         pre <= 3'h4;
      end
      if (txValid && macTxReady && txLast) inFrame <= 1'b0;
   end
endmodule : edd_far_model

// ==== edd_frame_dma_tb.sv ====
// Self-checking bench for the frame DMA engine
`timescale 1ns/1ps
`include "edd_defs.svh"
module edd_frame_dma_tb;
   localparam logic [2:0] TC = 3'b101, TM = 3'b110, TW = 3'b010;
   logic core_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, rxData = '0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic rxValid = 1'b0, rxLast = 1'b0, rxCrcErr = 1'b0, carrierOn = 1'b0;
   wire logic hreadyout, hresp, irqOut, memReq, memWrite, memAck, txValid;
   wire logic txLast, macTxReady, macTxPreamble, macCarrier, macTxDone;
   wire logic rxReady;
   wire logic [31:0] hrdata, memAddr, memWdata, memRdata, txData;
   wire logic [3:0] memLen;
   int fails = 0, compares = 0, cyc = 0;
   logic [64:0] regQ [$];
   logic [32:0] txQ [$];
   event gotRd;
   edd_frame_dma dut (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .irqOut, .memReq, .memWrite, .memAddr, .memLen, .memWdata, .memAck,
      .memRdata, .txData, .txValid, .txLast, .macTxReady, .macTxPreamble,
      .macCarrier, .macTxDone, .rxData, .rxValid, .rxLast, .rxCrcErr,
      .rxReady);
   edd_far_model far (.core_clk, .memReq, .memWrite, .memAddr, .memLen,
      .memWdata, .memAck, .memRdata, .txValid, .txLast, .macTxReady,
      .macTxPreamble, .macCarrier, .macTxDone, .carrierOn);
   initial forever #5 core_clk = ~core_clk;
   task automatic chk(input logic [32:0] g, e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic stop_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test
   // One AHB single transfer, address phase then data phase
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge core_clk iff hreadyout);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge core_clk iff hreadyout);
      r = hrdata;
   endtask : ahb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      regQ.push_back({1'b0, m, e});
      ->gotRd;
   endtask : rd
   task automatic poll(input logic [7:0] a, input int b, input logic v);
      logic [31:0] r;
      for (int i = 0; i < 300; i++) begin
         ahb(1'b0, a, 32'h0, r);
         if (r[b] === v) return;
      end
      chk(33'h0, 33'h1);
   endtask : poll
   // Register read results against the oldest note
   always @(gotRd) begin
      logic [64:0] q;
      q = regQ.pop_front();
      chk(33'(hrdata & q[63:32]), 33'(q[31:0]));
   end
   // Watchdog, MAC words and burst sizes
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fails++;
         stop_test();
      end
      if (txValid && macTxReady) chk({txLast, txData}, txQ.pop_front());
      if (memReq && memAck) chk(33'(memLen <= 4'h8), 33'h1);
   end
   initial begin
      int n;
      logic [31:0] v;
      logic [31:0] rxw [3];
      void'($urandom(32'hca4efc7e));
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      rd(`EDD_A_CTRL, 32'h1, '1);
      rd(8'h30, 32'h0, '1);
      wr(8'h30, 32'h55);
      rd(`EDD_A_TDF, 32'h0, '1);
      wr(`EDD_A_MSK, 32'hf);
      // Stopped engine leaves an owned descriptor alone
      far.mem[64] = 32'h80000004;
      far.mem[65] = 32'h200;
      far.mem[66] = 32'h0;
      wr(`EDD_A_TXB, 32'h100);
      wr(`EDD_A_CTRL, 32'h3);
      repeat (40) @(posedge core_clk);
      rd(`EDD_A_TDF, 32'h0, '1);
      // Transmit frames over carrier and interrupt modes
      for (int t = 0; t < 3; t++) begin
         n = $urandom_range(10, 1);
         far.mem[64] = {2'h2, TW[t], 13'h0, 16'(4 * n)};
         for (int i = 0; i < n; i++) begin
            far.mem[128 + i] = $urandom;
            txQ.push_back({1'(i == n - 1), far.mem[128 + i]});
         end
         carrierOn <= TC[t];
         wr(`EDD_A_TIM, {31'h0, TM[t]});
         wr(`EDD_A_TXB, 32'h100);
         wr(`EDD_A_CTRL, 32'h2);
         poll(`EDD_A_CTRL, 1, 1'b0);
         rd(`EDD_A_STS, {28'h0, !TC[t], 2'h0, t != 2}, 32'h9);
         chk(33'(irqOut), 33'(t != 2));
         rd(`EDD_A_TDF, 32'h108, '1);
         rd(`EDD_A_TBR, 32'h200 + 32'(4 * n - 4), '1);
         chk(33'(far.mem[64] & 32'h84000000), 33'({!TC[t], 26'h0}));
         wr(`EDD_A_MSK, 32'h0);
         rd(`EDD_A_MSK, 32'h0, '1);
         chk(33'(irqOut), 33'h0);
         wr(`EDD_A_STS, 32'hf);
         wr(`EDD_A_MSK, 32'hf);
      end
      // Receive two frames with padding, CRC mode both ways
      far.mem[192] = 32'h80000000;
      far.mem[193] = 32'h400;
      far.mem[194] = 32'h80000000;
      far.mem[195] = 32'h440;
      far.mem[196] = 32'h0;
      wr(`EDD_A_RXB, 32'h300);
      for (int k = 0; k < 2; k++) begin
         far.mem[256 + 16 * k] = '1;
         wr(`EDD_A_CTRL, {26'h0, 2'h1, 1'(k), 3'h4});
         for (int i = 0; i < 3; i++) begin
            v = $urandom;
            rxw[i] = v;
            rxData <= v;
            rxValid <= 1'b1;
            rxLast <= i == 2;
            rxCrcErr <= i == 2;
            @(posedge core_clk iff rxReady);
         end
         rxValid <= 1'b0;
         rxLast <= 1'b0;
         rxCrcErr <= 1'b0;
         poll(`EDD_A_STS, 1, 1'b1);
         rd(`EDD_A_STS, {29'h0, k == 0, 2'h2}, 32'h6);
         wr(`EDD_A_STS, 32'h6);
         chk(33'(far.mem[192 + 2 * k] & 32'h8800ffff),
             33'({4'h0, k == 0, 27'hc}));
         chk(33'(far.mem[256 + 16 * k]), 33'h0);
         for (int i = 0; i < 3; i++)
            chk(33'(far.mem[257 + 16 * k + i]), 33'(rxw[i]));
         rd(`EDD_A_RBW, 32'h40c + 32'(64 * k), '1);
         rd(`EDD_A_RDF, 32'h300 + 32'(8 * k), '1);
      end
      stop_test();
   end
endmodule : edd_frame_dma_tb
